// ==== design/dsc_defines.svh ====
// constants for the display scroll / idle / format / memory command block
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// ************************************************************
// command codes
// ************************************************************
`define DSC_CMD_COL_SET 8'h2A
`define DSC_CMD_PAGE_SET 8'h2B
`define DSC_CMD_WR_START 8'h2C
`define DSC_CMD_RD_START 8'h2E
`define DSC_CMD_TEAR_OFF 8'h34
`define DSC_CMD_TEAR_ON 8'h35
`define DSC_CMD_MAC 8'h36
`define DSC_CMD_SCROLL 8'h37
`define DSC_CMD_IDLE_EXIT 8'h38
`define DSC_CMD_IDLE_ENTRY 8'h39
`define DSC_CMD_DEPTH 8'h3A
`define DSC_CMD_WR_CONT 8'h3C
`define DSC_CMD_RD_CONT 8'h3E
`define DSC_CMD_TEAR_LINE 8'h44

// ************************************************************
// fields and reset values
// ************************************************************
`define DSC_DEPTH_MASK 8'h77
`define DSC_DEPTH_CTL_LSB 0
`define DSC_DEPTH_LINK_LSB 4
`define DSC_DEPTH_RESET 8'h66
`define DSC_SCROLL_RESET 16'h0000
`define DSC_TEAR_LINE_RESET 16'h0000
`define DSC_FIFO_DEPTH 16

`endif

// ==== design/dsc_pkg.sv ====
// types shared by both ends of the command link
package dsc_pkg;
  typedef enum logic [3:0] {
    DSC_DS_IDLE  = 4'h1,
    DSC_DS_PARAM = 4'h2,
    DSC_DS_WRITE = 4'h4,
    DSC_DS_READ  = 4'h8
  } dsc_dev_state_t;

  typedef enum logic [3:0] {
    DSC_HS_PASS = 4'h1,
    DSC_HS_HI   = 4'h2,
    DSC_HS_LO   = 4'h4,
    DSC_HS_SEND = 4'h8
  } dsc_host_state_t;

  typedef logic [17:0] dsc_pixel_t;
endpackage

// ==== design/dsc_link_if.sv ====
// command link between host processor and display command decoder
interface dsc_link_if;
  logic valid;
  logic dcs;
  logic [17:0] data;
  logic ready;
  logic rd_req;
  logic rd_valid;
  logic [17:0] rd_data;
  logic tear;

  modport dev (
    input valid, dcs, data, rd_req,
    output ready, rd_valid, rd_data, tear
  );
  modport host (
    output valid, dcs, data, rd_req,
    input ready, rd_valid, rd_data, tear
  );
endinterface

// ==== design/dsc_fifo.sv ====
// pixel write fifo, flip-flop storage
module dsc_fifo #(
  parameter int W = 50,
  parameter int D = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
endmodule

// ==== design/dsc_device.sv ====
// display side: command decoder, scroll/idle/format/tear state, memory continue
`include "dsc_defines.svh"
module dsc_device #(
  parameter int FIFO_DEPTH = `DSC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // command link
  dsc_link_if.dev link,
  // address window and access control, owned elsewhere
  input wire logic row_column_exchange_i,
  input wire logic [15:0] start_column_i,
  input wire logic [15:0] end_column_i,
  input wire logic [15:0] start_page_i,
  input wire logic [15:0] end_page_i,
  // frame memory port
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [15:0] mem_col_o,
  output logic [15:0] mem_page_o,
  output logic [17:0] mem_wdata_o,
  input wire logic [17:0] mem_rdata_i,
  input wire logic mem_ready_i,
  // panel scan
  input wire logic frame_start_i,
  input wire logic [15:0] scanline_i,
  input wire logic [17:0] disp_pix_i,
  output logic [17:0] disp_pix_o,
  output logic [15:0] scroll_line_pointer_o,
  output logic reduced_colour_o,
  output logic [2:0] ctl_depth_o,
  output logic [2:0] link_depth_o
);
  localparam int FW = 50;

  dsc_pkg::dsc_dev_state_t st_q, st_d;
  logic [7:0] cmd_q, cmd_d;
  logic idx_q, idx_d;
  logic [7:0] hi_q, hi_d;
  logic [15:0] scroll_pend_q, scroll_pend_d;
  logic pend_q, pend_d;
  logic [15:0] scroll_q, scroll_d;
  logic idle_q, idle_d;
  logic [7:0] depth_q, depth_d;
  logic [15:0] tear_line_q, tear_line_d;
  logic tear_on_q, tear_on_d;
  logic tear_q, tear_d;
  logic win_ok_q, win_ok_d;
  logic [15:0] col_q, col_d, page_q, page_d;
  logic dummy_q, dummy_d;
  logic rd1_q, rd1_d, rd1_zero_q, rd1_zero_d;
  logic rd_valid_q, rd_valid_d;
  logic [17:0] rd_data_q, rd_data_d;
  logic mem_we_q, mem_we_d, mem_re_q, mem_re_d;
  logic [15:0] mcol_q, mcol_d, mpage_q, mpage_d;
  logic [17:0] wdata_q, wdata_d;
  logic [17:0] pix_q, pix_d;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [FW-1:0] fifo_out;
  logic take, rd_take;
  logic [15:0] ncol, npage;

  assign link.ready = fifo_in_ready & ((st_q != dsc_pkg::DSC_DS_READ) | ~fifo_out_valid);
  assign link.rd_valid = rd_valid_q;
  assign link.rd_data = rd_data_q;
  assign link.tear = tear_q;
  assign mem_we_o = mem_we_q;
  assign mem_re_o = mem_re_q;
  assign mem_col_o = mcol_q;
  assign mem_page_o = mpage_q;
  assign mem_wdata_o = wdata_q;
  assign disp_pix_o = pix_q;
  assign scroll_line_pointer_o = scroll_q;
  assign reduced_colour_o = idle_q;
  assign ctl_depth_o = depth_q[`DSC_DEPTH_CTL_LSB +: 3];
  assign link_depth_o = depth_q[`DSC_DEPTH_LINK_LSB +: 3];

  assign take = link.valid & link.ready;
  assign rd_take = link.rd_req & link.ready;
  assign fifo_in_valid = take & link.dcs & (st_q == dsc_pkg::DSC_DS_WRITE) & win_ok_q;
  assign fifo_pop = fifo_out_valid & mem_ready_i & ~rd1_q;

  // next pixel address inside the window
  always_comb begin
    ncol = col_q;
    npage = page_q;
    if (!row_column_exchange_i) begin
      if (col_q == end_column_i) begin
        ncol = start_column_i;
        npage = (page_q == end_page_i) ? start_page_i : page_q + 16'h0001;
      end else begin
        ncol = col_q + 16'h0001;
      end
    end else begin
      if (page_q == end_page_i) begin
        npage = start_page_i;
        ncol = (col_q == end_column_i) ? start_column_i : col_q + 16'h0001;
      end else begin
        npage = page_q + 16'h0001;
      end
    end
  end

  // ************************************************************
  // command and parameter decode
  // ************************************************************
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    idx_d = idx_q;
    hi_d = hi_q;
    scroll_pend_d = scroll_pend_q;
    pend_d = pend_q;
    scroll_d = scroll_q;
    idle_d = idle_q;
    depth_d = depth_q;
    tear_line_d = tear_line_q;
    tear_on_d = tear_on_q;
    win_ok_d = win_ok_q;
    col_d = col_q;
    page_d = page_q;
    dummy_d = dummy_q;
    if (frame_start_i && pend_q) begin
      scroll_d = scroll_pend_q;
      pend_d = 1'b0;
    end
    if (take && !link.dcs) begin
      cmd_d = link.data[7:0];
      idx_d = 1'b0;
      st_d = dsc_pkg::DSC_DS_IDLE;
      case (link.data[7:0])
        `DSC_CMD_IDLE_EXIT: idle_d = 1'b0;
        `DSC_CMD_IDLE_ENTRY: idle_d = 1'b1;
        `DSC_CMD_TEAR_OFF: tear_on_d = 1'b0;
        `DSC_CMD_SCROLL, `DSC_CMD_DEPTH, `DSC_CMD_TEAR_LINE, `DSC_CMD_TEAR_ON: begin
          st_d = dsc_pkg::DSC_DS_PARAM;
        end
        `DSC_CMD_WR_START: begin
          win_ok_d = 1'b1;
          col_d = start_column_i;
          page_d = start_page_i;
          st_d = dsc_pkg::DSC_DS_WRITE;
        end
        `DSC_CMD_RD_START: begin
          win_ok_d = 1'b1;
          col_d = start_column_i;
          page_d = start_page_i;
          dummy_d = 1'b1;
          st_d = dsc_pkg::DSC_DS_READ;
        end
        `DSC_CMD_WR_CONT: st_d = dsc_pkg::DSC_DS_WRITE;
        `DSC_CMD_RD_CONT: begin
          dummy_d = 1'b1;
          st_d = dsc_pkg::DSC_DS_READ;
        end
        default: st_d = dsc_pkg::DSC_DS_IDLE;
      endcase
    end else if (take && st_q == dsc_pkg::DSC_DS_PARAM) begin
      idx_d = 1'b1;
      case (cmd_q)
        `DSC_CMD_SCROLL: begin
          if (!idx_q) begin
            hi_d = link.data[7:0];
          end else begin
            scroll_pend_d = {hi_q, link.data[7:0]};
            pend_d = 1'b1;
            st_d = dsc_pkg::DSC_DS_IDLE;
          end
        end
        `DSC_CMD_TEAR_LINE: begin
          if (!idx_q) begin
            hi_d = link.data[7:0];
          end else begin
            tear_line_d = {hi_q, link.data[7:0]};
            st_d = dsc_pkg::DSC_DS_IDLE;
          end
        end
        `DSC_CMD_DEPTH: begin
          depth_d = link.data[7:0] & `DSC_DEPTH_MASK;
          st_d = dsc_pkg::DSC_DS_IDLE;
        end
        default: begin
          tear_on_d = 1'b1;
          st_d = dsc_pkg::DSC_DS_IDLE;
        end
      endcase
    end else if (take && st_q == dsc_pkg::DSC_DS_WRITE) begin
      col_d = ncol;
      page_d = npage;
    end
    if (rd_take && st_q == dsc_pkg::DSC_DS_READ) begin
      if (dummy_q) begin
        dummy_d = 1'b0;
      end else begin
        col_d = ncol;
        page_d = npage;
      end
    end
  end

  // ************************************************************
  // memory port, read answer, tear and display outputs
  // ************************************************************
  always_comb begin
    rd1_d = rd_take;
    rd1_zero_d = (st_q != dsc_pkg::DSC_DS_READ) | dummy_q | ~win_ok_q;
    mem_re_d = rd_take & (st_q == dsc_pkg::DSC_DS_READ) & ~dummy_q & win_ok_q;
    mem_we_d = fifo_pop;
    mcol_d = mcol_q;
    mpage_d = mpage_q;
    wdata_d = wdata_q;
    if (mem_re_d) begin
      mcol_d = col_q;
      mpage_d = page_q;
    end else if (fifo_pop) begin
      {mcol_d, mpage_d, wdata_d} = fifo_out;
    end
    rd_valid_d = rd1_q;
    rd_data_d = rd1_zero_q ? 18'h00000 : mem_rdata_i;
    tear_d = tear_on_q & (scanline_i == tear_line_q);
    pix_d = idle_q ? {{6{disp_pix_i[17]}}, {6{disp_pix_i[11]}}, {6{disp_pix_i[5]}}} : disp_pix_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= dsc_pkg::DSC_DS_IDLE;
      cmd_q <= 8'h00;
      idx_q <= 1'b0;
      hi_q <= 8'h00;
      scroll_pend_q <= `DSC_SCROLL_RESET;
      pend_q <= 1'b0;
      scroll_q <= `DSC_SCROLL_RESET;
      idle_q <= 1'b0;
      depth_q <= `DSC_DEPTH_RESET;
      tear_line_q <= `DSC_TEAR_LINE_RESET;
      tear_on_q <= 1'b0;
      tear_q <= 1'b0;
      win_ok_q <= 1'b0;
      col_q <= 16'h0000;
      page_q <= 16'h0000;
      dummy_q <= 1'b0;
      rd1_q <= 1'b0;
      rd1_zero_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 18'h00000;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      mcol_q <= 16'h0000;
      mpage_q <= 16'h0000;
      wdata_q <= 18'h00000;
      pix_q <= 18'h00000;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      idx_q <= idx_d;
      hi_q <= hi_d;
      scroll_pend_q <= scroll_pend_d;
      pend_q <= pend_d;
      scroll_q <= scroll_d;
      idle_q <= idle_d;
      depth_q <= depth_d;
      tear_line_q <= tear_line_d;
      tear_on_q <= tear_on_d;
      tear_q <= tear_d;
      win_ok_q <= win_ok_d;
      col_q <= col_d;
      page_q <= page_d;
      dummy_q <= dummy_d;
      rd1_q <= rd1_d;
      rd1_zero_q <= rd1_zero_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      mem_we_q <= mem_we_d;
      mem_re_q <= mem_re_d;
      mcol_q <= mcol_d;
      mpage_q <= mpage_d;
      wdata_q <= wdata_d;
      pix_q <= pix_d;
    end
  end

  dsc_fifo #(
    .W(FW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i({col_q, page_q, link.data}),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out),
    .out_ready_i(fifo_pop)
  );
endmodule

// ==== design/dsc_host.sv ====
// host side: forwards commands, clamps scroll pointer, checks read order
`include "dsc_defines.svh"
module dsc_host (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // command link
  dsc_link_if.host link,
  // user command stream
  input wire logic cmd_valid_i,
  input wire logic cmd_dcs_i,
  input wire logic [17:0] cmd_data_i,
  output logic cmd_ready_o,
  // user reads
  input wire logic rd_req_i,
  output logic rd_valid_o,
  output logic [17:0] rd_data_o,
  // scroll limits and status
  input wire logic [15:0] scroll_min_i,
  input wire logic [15:0] scroll_max_i,
  output logic order_err_o,
  output logic tear_o
);
  dsc_pkg::dsc_host_state_t st_q, st_d;
  logic ov_q, ov_d, odc_q, odc_d;
  logic [17:0] od_q, od_d;
  logic rdy_q, rdy_d;
  logic [7:0] hi_q, hi_d, lo_q, lo_d;
  logic def_q, def_d, err_q, err_d;
  logic rdreq_q, rdv_q, tear_q;
  logic [17:0] rdd_q;
  logic acc;
  logic [15:0] ptr, cptr;

  assign link.valid = ov_q;
  assign link.dcs = odc_q;
  assign link.data = od_q;
  assign link.rd_req = rdreq_q;
  assign cmd_ready_o = rdy_q;
  assign rd_valid_o = rdv_q;
  assign rd_data_o = rdd_q;
  assign order_err_o = err_q;
  assign tear_o = tear_q;
  assign acc = cmd_valid_i & rdy_q;
  assign ptr = {hi_q, cmd_data_i[7:0]};
  assign cptr = (ptr < scroll_min_i) ? scroll_min_i : (ptr > scroll_max_i) ? scroll_max_i : ptr;

  always_comb begin
    st_d = st_q;
    ov_d = ov_q & ~link.ready;
    odc_d = odc_q;
    od_d = od_q;
    hi_d = hi_q;
    lo_d = lo_q;
    def_d = def_q;
    err_d = 1'b0;
    if (acc) begin
      ov_d = 1'b1;
      odc_d = cmd_dcs_i;
      od_d = cmd_data_i;
      if (!cmd_dcs_i) begin
        st_d = (cmd_data_i[7:0] == `DSC_CMD_SCROLL) ? dsc_pkg::DSC_HS_HI : dsc_pkg::DSC_HS_PASS;
        if (cmd_data_i[7:0] == `DSC_CMD_COL_SET || cmd_data_i[7:0] == `DSC_CMD_PAGE_SET ||
            cmd_data_i[7:0] == `DSC_CMD_MAC) begin
          def_d = 1'b1;
        end
        if (cmd_data_i[7:0] == `DSC_CMD_RD_START && !def_q) begin
          err_d = 1'b1;
        end
      end else if (st_q == dsc_pkg::DSC_HS_HI) begin
        ov_d = 1'b0;
        hi_d = cmd_data_i[7:0];
        st_d = dsc_pkg::DSC_HS_LO;
      end else if (st_q == dsc_pkg::DSC_HS_LO) begin
        od_d = {10'h000, cptr[15:8]};
        lo_d = cptr[7:0];
        st_d = dsc_pkg::DSC_HS_SEND;
      end
    end else if (st_q == dsc_pkg::DSC_HS_SEND && !ov_d) begin
      ov_d = 1'b1;
      odc_d = 1'b1;
      od_d = {10'h000, lo_q};
      st_d = dsc_pkg::DSC_HS_PASS;
    end
    rdy_d = ~ov_d & (st_d != dsc_pkg::DSC_HS_SEND) & ~acc;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= dsc_pkg::DSC_HS_PASS;
      ov_q <= 1'b0;
      odc_q <= 1'b0;
      od_q <= 18'h00000;
      rdy_q <= 1'b0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      def_q <= 1'b0;
      err_q <= 1'b0;
      rdreq_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= 18'h00000;
      tear_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ov_q <= ov_d;
      odc_q <= odc_d;
      od_q <= od_d;
      rdy_q <= rdy_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      def_q <= def_d;
      err_q <= err_d;
      // read request held until the device takes it
      rdreq_q <= rdreq_q ? ~link.ready : rd_req_i;
      rdv_q <= link.rd_valid;
      rdd_q <= link.rd_data;
      tear_q <= link.tear;
    end
  end
endmodule

// ==== bench/dsc_link_monitor.sv ====
// link checker: read timing and tear output rules on the command link
module dsc_link_monitor (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // link signals
  input wire logic valid,
  input wire logic dcs,
  input wire logic [17:0] data,
  input wire logic ready,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [17:0] rd_data,
  input wire logic tear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ****************
  // tracked link state
  // ****************
  logic cmd_tk, first_q, first_d, on_q, on_d, pend_q, pend_d;
  assign cmd_tk = valid && ready && !dcs;
  always_comb begin
    first_d = first_q;
    if (rd_req && ready) first_d = 1'b0;
    if (cmd_tk && (data[7:0] == 8'h2E || data[7:0] == 8'h3E)) first_d = 1'b1;
    pend_d = cmd_tk ? (data[7:0] == 8'h35) : (pend_q && !(valid && ready));
    on_d = on_q;
    if (pend_q && valid && ready && dcs) on_d = 1'b1;
    if (cmd_tk && data[7:0] == 8'h34) on_d = 1'b0;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_q <= 1'b0;
      on_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      first_q <= first_d;
      on_q <= on_d;
      pend_q <= pend_d;
    end
  end
  a_read_answer_time: assert property (rd_req && ready |-> ##2 rd_valid)
    else $error("read answer not two cycles after request");
  a_read_has_cause: assert property (rd_valid |-> $past(rd_req && ready, 2))
    else $error("read answer without request");
  a_dummy_read_zero: assert property (rd_req && ready && first_q |-> ##2 rd_data == 18'h00000)
    else $error("first read word not dummy");
  a_beat_stays_up: assert property (valid && !ready |=> valid)
    else $error("beat withdrawn before taken");
  a_beat_held_stable: assert property (valid && !ready |=> $stable(data) && $stable(dcs))
    else $error("beat changed before taken");
  a_tear_off_quiet: assert property (!on_q && $past(!on_q) |-> !tear)
    else $error("tear output while off");
  a_tear_needs_on: assert property ($rose(tear) |-> $past(on_q))
    else $error("tear output rose while disabled");
  a_tear_reset_low: assert property ($rose(rst_b_i) |-> !tear [*2])
    else $error("tear output high after reset");
  cover property (rd_valid && rd_data != 18'h00000);
  cover property (valid && !ready);
  cover property ($rose(tear));
  cover property (cmd_tk && data[7:0] == 8'h3C);
endmodule

// ==== bench/tb_display_scroll_idle_format_memory_cmds.sv ====
// testbench: host and device ends joined over the command link
module tb_display_scroll_idle_format_memory_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COL_LO = 2, COL_HI = 4, PG_LO = 1, PG_HI = 3;
  logic core_clk_i, rst_b_i, xchg, mem_ready_i, frame_start_i, stall;
  logic cmd_valid_i, cmd_dcs_i, cmd_ready_o, rd_req_i, rd_valid_o, order_err_o, tear_o;
  logic mem_we_o, mem_re_o, reduced_colour_o, err_seen, saw_full;
  logic [15:0] scanline_i, scroll_min_i, scroll_max_i, mem_col_o, mem_page_o, ptr, last;
  logic [17:0] cmd_data_i, rd_data_o, mem_wdata_o, mem_rdata_i, disp_pix_i, disp_pix_o, p;
  logic [2:0] ctl_depth_o, link_depth_o;
  logic [2:0] codes [3] = '{3'b011, 3'b101, 3'b110};
  logic [15:0] sv [3] = '{16'h0123, 16'h0005, 16'hFFFF};
  int n_fail = 0, cmp_count = 0, seed = 54, cyc = 0, wc, wp, rc, rp;
  int eq_a[$];
  logic [17:0] eq_d[$];
  logic [17:0] mem[int];
  logic [17:0] emem[int];
  dsc_link_if link();
  dsc_device #(.FIFO_DEPTH(16)) i_dsc_device (.core_clk_i, .rst_b_i, .link(link),
    .row_column_exchange_i(xchg), .start_column_i(16'(COL_LO)), .end_column_i(16'(COL_HI)),
    .start_page_i(16'(PG_LO)), .end_page_i(16'(PG_HI)), .mem_we_o, .mem_re_o, .mem_col_o,
    .mem_page_o, .mem_wdata_o, .mem_rdata_i, .mem_ready_i, .frame_start_i, .scanline_i,
    .disp_pix_i, .disp_pix_o, .scroll_line_pointer_o(ptr), .reduced_colour_o,
    .ctl_depth_o, .link_depth_o);
  dsc_host i_dsc_host (.core_clk_i, .rst_b_i, .link(link), .cmd_valid_i, .cmd_dcs_i,
    .cmd_data_i, .cmd_ready_o, .rd_req_i, .rd_valid_o, .rd_data_o, .scroll_min_i,
    .scroll_max_i, .order_err_o, .tear_o);
  dsc_link_monitor i_dsc_link_monitor (.core_clk_i, .rst_b_i, .valid(link.valid),
    .dcs(link.dcs), .data(link.data), .ready(link.ready), .rd_req(link.rd_req),
    .rd_valid(link.rd_valid), .rd_data(link.rd_data), .tear(link.tear));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // ****************
  // frame memory, watchdog
  // ****************
  always @(posedge core_clk_i) begin : env
    int a;
    a = {mem_page_o, mem_col_o};
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
    if (mem_we_o === 1'b1) begin
      if (eq_a.size() == 0) chk(0, 1, "stray write");
      else begin
        chk(a, eq_a.pop_front(), "write address");
        chk(mem_wdata_o, eq_d.pop_front(), "write data");
        mem[a] = mem_wdata_o;
      end
    end
    if (order_err_o === 1'b1) err_seen = 1'b1;
    if (link.valid === 1'b1 && link.ready === 1'b0) saw_full = 1'b1;
    #1;
    // read port answers within the cycle in which the strobe stands
    a = {mem_page_o, mem_col_o};
    mem_ready_i = !stall && ($random(seed) % 4 != 0);
    mem_rdata_i = mem_re_o ? (mem.exists(a) ? mem[a] : 18'h00000) : 18'($random(seed));
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic send(input logic d, input logic [17:0] x);
    #1;
    cmd_valid_i = 1'b1;
    cmd_dcs_i = d;
    cmd_data_i = x;
    do @(posedge core_clk_i); while (cmd_ready_o !== 1'b1);
  endtask
  task automatic quiet(input int n);
    #1;
    cmd_valid_i = 1'b0;
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [17:0] exp, input string m);
    int k;
    #1;
    rd_req_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    rd_req_i = 1'b0;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (rd_valid_o !== 1'b1 && k < 20);
    chk(rd_valid_o, 1'b1, "read answer");
    chk(rd_data_o, exp, m);
  endtask
  function automatic void step(inout int f, inout int s, input int f0, f1, s0, s1);
    if (f == f1) begin
      f = f0;
      s = (s == s1) ? s0 : s + 1;
    end else f = f + 1;
  endfunction
  task automatic adv(inout int c, inout int r);
    if (xchg) step(r, c, PG_LO, PG_HI, COL_LO, COL_HI);
    else step(c, r, COL_LO, COL_HI, PG_LO, PG_HI);
  endtask
  task automatic pix(input int n, input bit keep);
    logic [17:0] x;
    repeat (n) begin
      x = 18'($random(seed));
      if (keep) begin
        eq_a.push_back((wp << 16) | wc);
        eq_d.push_back(x);
        emem[(wp << 16) | wc] = x;
        adv(wc, wp);
      end
      send(1'b1, x);
    end
  endtask
  task automatic rdn(input int n);
    repeat (n) begin
      rd(emem[(rp << 16) | rc], "pixel");
      adv(rc, rp);
    end
  endtask
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    {rst_b_i, cmd_valid_i, cmd_dcs_i, rd_req_i, frame_start_i, xchg, stall} = '0;
    {err_seen, saw_full, mem_ready_i, cmd_data_i, mem_rdata_i, disp_pix_i, scanline_i} = '0;
    scroll_min_i = 16'h000A;
    scroll_max_i = 16'h012C;
    last = 16'h0000;
    repeat (3) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    @(posedge core_clk_i);
    chk(ctl_depth_o, 3'b110, "ctl depth");
    chk(link_depth_o, 3'b110, "link depth");
    chk(reduced_colour_o, 1'b0, "idle");
    chk(ptr, 16'h0000, "pointer");
    $display("test reset done");
    send(1'b0, 18'h0003C);
    pix(2, 1'b0);
    send(1'b0, 18'h0003E);
    quiet(2);
    rd(18'h00000, "dummy");
    rd(18'h00000, "undefined read");
    send(1'b0, 18'h0002E);
    quiet(4);
    chk(err_seen, 1'b1, "read order");
    $display("test undefined continue done");
    for (int i = 0; i < 3; i++) begin
      send(1'b0, 18'h0003A);
      send(1'b1, {10'h000, 1'b1, codes[i], 1'b1, codes[(i + 1) % 3]});
      quiet(4);
      chk(link_depth_o, codes[i], "link depth");
      chk(ctl_depth_o, codes[(i + 1) % 3], "ctl depth");
    end
    $display("test depth done");
    for (int k = 0; k < 4; k++) begin
      send(1'b0, k < 2 ? 18'h00039 : 18'h00038);
      quiet(4);
      #1 disp_pix_i = 18'($random(seed));
      p = disp_pix_i;
      repeat (2) @(posedge core_clk_i);
      chk(reduced_colour_o, k < 2, "idle");
      chk(disp_pix_o, k < 2 ? {{6{p[17]}}, {6{p[11]}}, {6{p[5]}}} : p, "pixel");
    end
    $display("test idle done");
    for (int i = 0; i < 3; i++) begin
      send(1'b0, 18'h00037);
      send(1'b1, 18'(sv[i][15:8]));
      send(1'b1, 18'(sv[i][7:0]));
      quiet(4);
      chk(ptr, last, "pointer early");
      #1 frame_start_i = 1'b1;
      @(posedge core_clk_i);
      #1 frame_start_i = 1'b0;
      repeat (3) @(posedge core_clk_i);
      last = sv[i] < scroll_min_i ? scroll_min_i : (sv[i] > scroll_max_i ? scroll_max_i : sv[i]);
      chk(ptr, last, "pointer");
    end
    $display("test scroll done");
    send(1'b0, 18'h00044);
    send(1'b1, 18'h00000);
    send(1'b1, 18'h000C8);
    send(1'b0, 18'h00035);
    send(1'b1, 18'h00000);
    for (int j = 0; j < 3; j++) begin
      if (j == 2) send(1'b0, 18'h00034);
      quiet(2);
      #1 scanline_i = (j == 1) ? 16'h00C9 : 16'h00C8;
      repeat (4) @(posedge core_clk_i);
      chk(tear_o, j == 0, "tear");
    end
    $display("test tear done");
    for (int x = 0; x < 2; x++) begin
      #1 xchg = (x == 1);
      stall = 1'b1;
      saw_full = 1'b0;
      wc = COL_LO;
      wp = PG_LO;
      fork
        begin
          repeat (60) @(posedge core_clk_i);
          #1 stall = 1'b0;
        end
      join_none
      send(1'b0, 18'h0002A);
      send(1'b0, 18'h0002C);
      pix(12, 1'b1);
      send(1'b0, 18'h0003C);
      pix(8, 1'b1);
      quiet(60);
      chk(saw_full, 1'b1, "fifo full");
      chk(eq_a.size(), 0, "writes left");
      rc = COL_LO;
      rp = PG_LO;
      send(1'b0, 18'h0002E);
      quiet(2);
      rd(18'h00000, "dummy");
      rdn(4);
      send(1'b0, 18'h0003E);
      quiet(2);
      rd(18'h00000, "dummy");
      rdn(3);
    end
    $display("test memory done");
    end_sim();
  end
endmodule
